/* hw/bgr_defs.vh */
`ifndef BGR_DEFS_VH
`define BGR_DEFS_VH

// command codes of the register bank
`define BGR_CMD_MODE        8'h03
`define BGR_CMD_ERR_MARGIN  8'h0C
`define BGR_CMD_REL_CHARGE  8'h0D
`define BGR_CMD_ABS_CHARGE  8'h0E
`define BGR_CMD_CAP_LEFT    8'h0F
`define BGR_CMD_FULL_MAH    8'h10
`define BGR_CMD_RUN_MIN     8'h11
`define BGR_CMD_AVG_MIN     8'h12
`define BGR_CMD_CHG_CUR     8'h14
`define BGR_CMD_CHG_VOLT    8'h15
`define BGR_CMD_STATUS      8'h16
`define BGR_CMD_CYCLES      8'h17
`define BGR_CMD_NOM_CAP     8'h18
`define BGR_CMD_NOM_VOLT    8'h19
`define BGR_CMD_SPEC_REV    8'h1A
`define BGR_CMD_DATE        8'h1B
`define BGR_CMD_SERIAL      8'h1C
`define BGR_CMD_MAKER_NAME  8'h20
`define BGR_CMD_PACK_NAME   8'h21

// status word bit positions
`define BGR_ST_OVERCHG      15
`define BGR_ST_TERM_CHG     14
`define BGR_ST_OVERTEMP     12
`define BGR_ST_TERM_DIS     11
`define BGR_ST_LOW_CAP      9
`define BGR_ST_LOW_TIME     8
`define BGR_ST_INIT         7
`define BGR_ST_DISCHG       6
`define BGR_ST_FULL         5
`define BGR_ST_EMPTY        4

// mode word bits
`define BGR_MODE_NO_VC      14
`define BGR_MODE_NO_ALL     13
`define BGR_MODE_RST        16'h0000

// value limits
`define BGR_PCT_MAX         16'h0064
`define BGR_NO_DATA         16'hFFFF
`define BGR_CYCLE_DROP      8'h0F
`define BGR_STR_MAX         8'h0F
`define BGR_SPEC_REV_RST    16'h0000

// pack removal timing
`define BGR_CLK_KHZ         125000
`define BGR_REMOVE_MS       2000
`define BGR_REMOVE_CYC      (`BGR_REMOVE_MS * `BGR_CLK_KHZ)

`endif

/* hw/bgr_readout_regs.v */
// Notes on behaviour
// - 0x0c error margin percent, 0 to 100.
// - 0x0d percent of learned full capacity, 0 to 100.
// - 0x0e percent of design capacity, may exceed 100.
// - 0x0f remaining capacity in mAh.
// - 0x10 full capacity, config value until learned.
// - 0x11 run time to empty, 65535 when not discharging.
// - 0x12 average time to empty, 65535 invalid.
// - 0x14 charge current request; 65535 voltage source.
// - 0x15 charge voltage request; 65535 current source.
// - status alarm bits 15,14,12,11,9,8; bits 13,10 reserved.
// - status bits 7 to 4, error code in bits 3:0.
// - low capacity alarm on remaining mAh, low time alarm on average time.
// - cycle count once per charge after 15 percent drop, saturates.
// - 0x18 design capacity in mAh.
// - 0x19 nominal pack voltage in mV.
// - 0x1a spec revision, all zeros.
// - 0x1b date: day 0-4, month 5-8, year-1980 9-15.
// - 0x1c pack serial number.
// - 0x20, 0x21 counted strings, count at most 15.
// - word or block transfer chosen by code.
// - low time alarm when average time below alarm.
// - mode bit 14 mutes charger; cleared after lines low 2 s.
`include "bgr_defs.vh"

module bgr_readout_regs #(
   parameter [6:0]  DEV_ADDR   = 7'h0B,
   parameter [31:0] REMOVE_CYC = `BGR_REMOVE_CYC
) (
   input  wire         clock_i,
   input  wire         rst_b_i,
   input  wire         scc_i,
   input  wire         scd_i,
   output wire         scd_out_o,
   output wire         scd_oe_b_o,
   input  wire [15:0]  error_margin_pct_i,
   input  wire [15:0]  relative_charge_pct_i,
   input  wire [15:0]  absolute_charge_pct_i,
   input  wire [15:0]  capacity_left_mah_i,
   input  wire [15:0]  cfg_full_mah_i,
   input  wire         cfg_load_i,
   input  wire [15:0]  learned_mah_i,
   input  wire         learned_valid_i,
   input  wire [15:0]  run_minutes_i,
   input  wire [15:0]  avg_minutes_i,
   input  wire [15:0]  charge_current_request_i,
   input  wire [15:0]  charge_voltage_request_i,
   input  wire [15:0]  cap_alarm_mah_i,
   input  wire [15:0]  time_alarm_min_i,
   input  wire [3:0]   alarm_flags_i,
   input  wire [2:0]   state_flags_i,
   input  wire         discharging_i,
   input  wire         charging_i,
   input  wire         charge_done_i,
   input  wire [3:0]   error_code_i,
   input  wire [15:0]  nominal_capacity_mah_i,
   input  wire [15:0]  nominal_voltage_mv_i,
   input  wire [4:0]   date_day_i,
   input  wire [3:0]   date_month_i,
   input  wire [6:0]   date_year_i,
   input  wire [15:0]  pack_serial_i,
   input  wire [127:0] maker_name_string_i,
   input  wire [127:0] pack_name_string_i,
   output reg  [15:0]  pack_status_word_o,
   output reg  [15:0]  cycle_tally_o,
   output reg  [15:0]  pack_mode_word_o,
   output reg          bcast_vc_en_o
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_CMD  = 3'h2;
   localparam [2:0] ST_WR   = 3'h3;
   localparam [2:0] ST_RD   = 3'h4;
   localparam [2:0] ST_WAIT = 3'h5;

   reg  [1:0]   scc_sync_ff;
   reg  [1:0]   scd_sync_ff;
   reg          scc_ff;
   reg          scd_ff;
   reg  [2:0]   st_ff;
   reg  [3:0]   cnt_ff;
   reg  [7:0]   shift_ff;
   reg  [7:0]   cmd_ff;
   reg  [4:0]   idx_ff;
   reg  [7:0]   wr_lo_ff;
   reg          drv_low_ff;
   reg  [15:0]  rd_word_ff;
   reg  [15:0]  full_mah_ff;
   reg  [7:0]   soc_base_ff;
   reg          deep_ff;
   reg  [31:0]  low_cnt_ff;
   reg  [15:0]  nxt_word;
   reg  [7:0]   nxt_tx;
   reg          is_block;
   wire         scc_now;
   wire         scd_now;
   wire         scc_rise;
   wire         scc_fall;
   wire         start_det;
   wire         stop_det;
   wire [127:0] str_sel;
   wire [7:0]   str_len;
   wire [7:0]   soc_byte;
   wire         rem_done;

   //--------------------------------------------------------------
   // link pin sampling
   //--------------------------------------------------------------
   // two stages per pin, then a third copy for edge finding
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scc_sync_ff <= 2'h3;
         scd_sync_ff <= 2'h3;
         scc_ff      <= 1'b1;
         scd_ff      <= 1'b1;
      end else begin
         scc_sync_ff <= {scc_sync_ff[0], scc_i};
         scd_sync_ff <= {scd_sync_ff[0], scd_i};
         scc_ff      <= scc_sync_ff[1];
         scd_ff      <= scd_sync_ff[1];
      end
   end

   assign scc_now   = scc_sync_ff[1];
   assign scd_now   = scd_sync_ff[1];
   assign scc_rise  = scc_now & ~scc_ff;
   assign scc_fall  = ~scc_now & scc_ff;
   assign start_det = scc_now & scc_ff & scd_ff & ~scd_now;
   assign stop_det  = scc_now & scc_ff & ~scd_ff & scd_now;

   // open drain: pull low only
   assign scd_out_o  = 1'b0;
   assign scd_oe_b_o = ~drv_low_ff;

   //--------------------------------------------------------------
   // value selection
   //--------------------------------------------------------------
   // string select
   assign str_sel = (cmd_ff == `BGR_CMD_MAKER_NAME) ? maker_name_string_i
                                                    : pack_name_string_i;
   assign str_len = (str_sel[7:0] > `BGR_STR_MAX) ? `BGR_STR_MAX
                                                  : str_sel[7:0];

   // word for the command code
   always @* begin
      nxt_word = 16'h0000;
      is_block = 1'b0;
      case (cmd_ff)
         `BGR_CMD_MODE: nxt_word = pack_mode_word_o;
         `BGR_CMD_ERR_MARGIN:
            nxt_word = (error_margin_pct_i > `BGR_PCT_MAX) ?
                       `BGR_PCT_MAX : error_margin_pct_i;
         `BGR_CMD_REL_CHARGE:
            nxt_word = (relative_charge_pct_i > `BGR_PCT_MAX) ?
                       `BGR_PCT_MAX : relative_charge_pct_i;
         `BGR_CMD_ABS_CHARGE: nxt_word = absolute_charge_pct_i;
         `BGR_CMD_CAP_LEFT:   nxt_word = capacity_left_mah_i;
         `BGR_CMD_FULL_MAH:   nxt_word = full_mah_ff;
         `BGR_CMD_RUN_MIN:
            nxt_word = discharging_i ? run_minutes_i : `BGR_NO_DATA;
         `BGR_CMD_AVG_MIN:    nxt_word = avg_minutes_i;
         `BGR_CMD_CHG_CUR:    nxt_word = charge_current_request_i;
         `BGR_CMD_CHG_VOLT:   nxt_word = charge_voltage_request_i;
         `BGR_CMD_STATUS:     nxt_word = pack_status_word_o;
         `BGR_CMD_CYCLES:     nxt_word = cycle_tally_o;
         `BGR_CMD_NOM_CAP:    nxt_word = nominal_capacity_mah_i;
         `BGR_CMD_NOM_VOLT:   nxt_word = nominal_voltage_mv_i;
         `BGR_CMD_SPEC_REV:   nxt_word = `BGR_SPEC_REV_RST;
         `BGR_CMD_DATE:
            nxt_word = {date_year_i, date_month_i, date_day_i};
         `BGR_CMD_SERIAL:     nxt_word = pack_serial_i;
         `BGR_CMD_MAKER_NAME: is_block = 1'b1;
         `BGR_CMD_PACK_NAME:  is_block = 1'b1;
         default:             nxt_word = 16'h0000;
      endcase
   end

   // byte to send at read position
   always @* begin
      nxt_tx = 8'hFF;
      if (is_block) begin
         if (idx_ff == 5'h00)
            nxt_tx = str_len;
         else if (idx_ff <= {1'b0, str_len[3:0]})
            nxt_tx = str_sel[{idx_ff[3:0], 3'h0} +: 8];
      end else if (idx_ff == 5'h00) begin
         nxt_tx = rd_word_ff[7:0];
      end else if (idx_ff == 5'h01) begin
         nxt_tx = rd_word_ff[15:8];
      end
   end

   //--------------------------------------------------------------
   // serial link engine
   //--------------------------------------------------------------
   // bits are taken on scc rise and driven after scc fall; the
   // word is snapshot when the read starts so both bytes match
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff      <= ST_IDLE;
         cnt_ff     <= 4'h0;
         shift_ff   <= 8'h00;
         cmd_ff     <= 8'h00;
         idx_ff     <= 5'h00;
         wr_lo_ff   <= 8'h00;
         drv_low_ff <= 1'b0;
         rd_word_ff <= 16'h0000;
      end else if (start_det) begin
         st_ff      <= ST_ADDR;
         cnt_ff     <= 4'h0;
         idx_ff     <= 5'h00;
         drv_low_ff <= 1'b0;
      end else if (stop_det) begin
         st_ff      <= ST_IDLE;
         drv_low_ff <= 1'b0;
      end else if (scc_rise && st_ff != ST_IDLE && st_ff != ST_WAIT) begin
         cnt_ff <= cnt_ff + 4'h1;
         if (cnt_ff < 4'h8)
            shift_ff <= {shift_ff[6:0], scd_now};
         // high ack: master wants no more
         if (st_ff == ST_RD && cnt_ff == 4'h8) begin
            if (scd_now)
               st_ff <= ST_WAIT;
            else
               idx_ff <= (idx_ff == 5'h1F) ? idx_ff : idx_ff + 5'h01;
         end
      end else if (scc_fall) begin
         case (st_ff)
            ST_ADDR: begin
               if (cnt_ff == 4'h8) begin
                  if (shift_ff[7:1] == DEV_ADDR)
                     drv_low_ff <= 1'b1;
                  else
                     st_ff <= ST_WAIT;
               end else if (cnt_ff == 4'h9) begin
                  cnt_ff <= 4'h0;
                  if (shift_ff[0]) begin
                     st_ff      <= ST_RD;
                     rd_word_ff <= nxt_word;
                     // first bit of low byte or count
                     drv_low_ff <= is_block ? ~str_len[7]
                                            : ~nxt_word[7];
                  end else begin
                     st_ff      <= ST_CMD;
                     drv_low_ff <= 1'b0;
                  end
               end
            end
            ST_CMD: begin
               if (cnt_ff == 4'h8) begin
                  drv_low_ff <= 1'b1;
                  cmd_ff     <= shift_ff;
               end else if (cnt_ff == 4'h9) begin
                  drv_low_ff <= 1'b0;
                  cnt_ff     <= 4'h0;
                  st_ff      <= ST_WR;
               end
            end
            ST_WR: begin
               if (cnt_ff == 4'h8) begin
                  drv_low_ff <= 1'b1;
                  if (idx_ff == 5'h00)
                     wr_lo_ff <= shift_ff;
               end else if (cnt_ff == 4'h9) begin
                  drv_low_ff <= 1'b0;
                  cnt_ff     <= 4'h0;
                  idx_ff     <= (idx_ff == 5'h1F) ? idx_ff
                                                  : idx_ff + 5'h01;
               end
            end
            ST_RD: begin
               if (cnt_ff < 4'h8)
                  drv_low_ff <= ~nxt_tx[3'h7 - cnt_ff[2:0]];
               else if (cnt_ff == 4'h8)
                  drv_low_ff <= 1'b0;
               else begin
                  cnt_ff     <= 4'h0;
                  drv_low_ff <= ~nxt_tx[7];
               end
            end
            default: drv_low_ff <= 1'b0;
         endcase
      end
   end

   //--------------------------------------------------------------
   // mode word and pack removal
   //--------------------------------------------------------------
   // both lines low this long: pack removed
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i)
         low_cnt_ff <= 32'h0;
      else if (scc_now || scd_now)
         low_cnt_ff <= 32'h0;
      else if (!rem_done)
         low_cnt_ff <= low_cnt_ff + 32'h1;
   end

   assign rem_done = (low_cnt_ff >= REMOVE_CYC);

   // only the mode word takes writes
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pack_mode_word_o <= `BGR_MODE_RST;
         bcast_vc_en_o    <= 1'b1;
      end else begin
         if (st_ff == ST_WR && scc_fall && cnt_ff == 4'h8 &&
             idx_ff == 5'h01 && cmd_ff == `BGR_CMD_MODE)
            pack_mode_word_o <= {shift_ff, wr_lo_ff};
         else if (rem_done)
            pack_mode_word_o[`BGR_MODE_NO_VC] <= 1'b0;
         bcast_vc_en_o <= ~pack_mode_word_o[`BGR_MODE_NO_VC] &
                          ~pack_mode_word_o[`BGR_MODE_NO_ALL];
      end
   end

   //--------------------------------------------------------------
   // capacity, cycles and status
   //--------------------------------------------------------------
   // config value until a learned one
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i)
         full_mah_ff <= 16'h0000;
      else if (learned_valid_i)
         full_mah_ff <= learned_mah_i;
      else if (cfg_load_i)
         full_mah_ff <= cfg_full_mah_i;
   end

   assign soc_byte = relative_charge_pct_i[7:0];

   // base is taken at each charge end; a deep enough drop arms
   // one count for the next charge so shallow cycles never count
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         soc_base_ff   <= 8'h00;
         deep_ff       <= 1'b0;
         cycle_tally_o <= 16'h0000;
      end else begin
         if (charge_done_i) begin
            soc_base_ff <= soc_byte;
            deep_ff     <= 1'b0;
         // arm after a 15 percent drop
         end else if ({1'b0, soc_byte} + {1'b0, `BGR_CYCLE_DROP} <=
                      {1'b0, soc_base_ff}) begin
            deep_ff <= 1'b1;
         end
         if (charging_i && deep_ff && !charge_done_i) begin
            deep_ff <= 1'b0;
            soc_base_ff <= 8'h00;
            if (cycle_tally_o != 16'hFFFF)
               cycle_tally_o <= cycle_tally_o + 16'h0001;
         end
      end
   end

   // status word from live flags
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pack_status_word_o <= 16'h0000;
      end else begin
         pack_status_word_o <= 16'h0000;
         pack_status_word_o[`BGR_ST_OVERCHG]  <= alarm_flags_i[3];
         pack_status_word_o[`BGR_ST_TERM_CHG] <= alarm_flags_i[2];
         pack_status_word_o[`BGR_ST_OVERTEMP] <= alarm_flags_i[1];
         pack_status_word_o[`BGR_ST_TERM_DIS] <= alarm_flags_i[0];
         pack_status_word_o[`BGR_ST_LOW_CAP] <=
            (capacity_left_mah_i < cap_alarm_mah_i);
         pack_status_word_o[`BGR_ST_LOW_TIME] <=
            (avg_minutes_i < time_alarm_min_i);
         pack_status_word_o[`BGR_ST_INIT]   <= state_flags_i[2];
         pack_status_word_o[`BGR_ST_DISCHG] <= discharging_i;
         pack_status_word_o[`BGR_ST_FULL]   <= state_flags_i[1];
         pack_status_word_o[`BGR_ST_EMPTY]  <= state_flags_i[0];
         pack_status_word_o[3:0]            <= error_code_i;
      end
   end

endmodule

/* sim/bgr_host_model.sv */
module bgr_host_model #(
   parameter logic [6:0] ADDR = 7'h0B
) (
   output logic scc_o,
   output wire  scd_o,
   input  wire  scd_oe_b_i
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam realtime Q = 31.25ns;
   logic       pull_low = 1'b0;
   logic [7:0] nak_cnt = 8'h00;
   initial scc_o = 1'b1;
   // pull-up: a released line reads high
   assign scd_o = ~(pull_low | ~scd_oe_b_i);
   // ----------------------------------------------------------------
   // bit and byte level, 125 ns per bit, data moves mid low phase
   // ----------------------------------------------------------------
   task automatic bit_o(input logic b);
      #Q pull_low = ~b;
      #Q scc_o = 1'b1;
      #(2*Q) scc_o = 1'b0;
   endtask
   task automatic bit_i(output logic b);
      #Q pull_low = 1'b0;
      #Q scc_o = 1'b1;
      #Q b = scd_o;
      #Q scc_o = 1'b0;
   endtask
   task automatic put_b(input logic [7:0] b);
      logic a;
      for (int i = 7; i >= 0; i--)
         bit_o(b[i]);
      bit_i(a);
      if (a !== 1'b0)
         nak_cnt++;
   endtask
   task automatic get_b(output logic [7:0] b, input logic last);
      for (int i = 7; i >= 0; i--)
         bit_i(b[i]);
      bit_o(last);
   endtask
   task automatic start();
      #Q pull_low = 1'b1;
      #Q scc_o = 1'b0;
   endtask
   task automatic rstart();
      #Q pull_low = 1'b0;
      #Q scc_o = 1'b1;
      start();
   endtask
   task automatic stop();
      #Q pull_low = 1'b1;
      #Q scc_o = 1'b1;
      #Q pull_low = 0;
      #(4*Q);
   endtask
   // ----------------------------------------------------------------
   // messages
   // ----------------------------------------------------------------
   // command picks the message kind
   task automatic head(input logic [7:0] c);
      start();
      put_b({ADDR, 1'b0});
      put_b(c);
      rstart();
      put_b({ADDR, 1'b1});
   endtask
   task automatic rd_word(input logic [7:0] c, output logic [15:0] w);
      head(c);
      get_b(w[7:0], 1'b0);
      get_b(w[15:8], 1'b1);
      stop();
   endtask
   task automatic wr_word(input logic [7:0] c, input logic [15:0] w);
      start();
      put_b({ADDR, 1'b0});
      put_b(c);
      put_b(w[7:0]);
      put_b(w[15:8]);
      stop();
   endtask
   // bound guards a bad count
   task automatic rd_blk(input logic [7:0] c, output logic [127:0] s);
      s = 128'h0;
      head(c);
      get_b(s[7:0], 1'b0);
      for (int k = 1; k <= s[7:0] && k < 16; k++)
         get_b(s[8*k +: 8], k == s[7:0] || k == 15);
      stop();
   endtask
   // both lines low, a pulled pack
   task automatic unplug(input realtime t);
      start();
      #t;
      stop();
   endtask
endmodule

/* sim/bgr_readout_monitor.sv */
module bgr_readout_monitor #(
   parameter [31:0] REMOVE_CYC = 32'h0000_00C8
) (
   input wire        clock_i,
   input wire        rst_b_i,
   input wire        scc_i,
   input wire        scd_i,
   input wire        scd_out_o,
   input wire        scd_oe_b_o,
   input wire [15:0] capacity_left_mah_i,
   input wire [15:0] cap_alarm_mah_i,
   input wire [15:0] avg_minutes_i,
   input wire [15:0] time_alarm_min_i,
   input wire [3:0]  alarm_flags_i,
   input wire [2:0]  state_flags_i,
   input wire        discharging_i,
   input wire [3:0]  error_code_i,
   input wire [15:0] pack_status_word_o,
   input wire [15:0] cycle_tally_o,
   input wire [15:0] pack_mode_word_o,
   input wire        bcast_vc_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] low_cnt_ff;
   default clocking mon_cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);
   // ----------------------------------------------------------------
   // removal detect
   // ----------------------------------------------------------------
   // raw both-low cycle count, saturating
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i)
         low_cnt_ff <= 32'h0;
      else if (scc_i | scd_i)
         low_cnt_ff <= 32'h0;
      else if (low_cnt_ff != 32'hFFFF_FFFF)
         low_cnt_ff <= low_cnt_ff + 32'h1;
   end
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_alarm_map:
   assert property ($past(rst_b_i) |-> {pack_status_word_o[15:14],
      pack_status_word_o[12:11]} == $past(alarm_flags_i))
      else $error("alarm bits wrong");
   a_state_map:
   assert property ($past(rst_b_i) |-> {pack_status_word_o[7],
      pack_status_word_o[5:4]} == $past(state_flags_i) &&
      pack_status_word_o[6] == $past(discharging_i) &&
      pack_status_word_o[3:0] == $past(error_code_i))
      else $error("state bits wrong");
   a_reserved_zero:
   assert property ({pack_status_word_o[13], pack_status_word_o[10]} == 2'h0)
      else $error("reserved status bit set");
   a_low_cap:
   assert property ($past(rst_b_i, 2) && $past(capacity_left_mah_i) ==
      $past(capacity_left_mah_i, 2) && $past(cap_alarm_mah_i) ==
      $past(cap_alarm_mah_i, 2) |-> pack_status_word_o[9] ==
      ($past(capacity_left_mah_i) < $past(cap_alarm_mah_i)))
      else $error("low capacity flag wrong");
   a_low_time:
   assert property ($past(rst_b_i, 2) && $past(avg_minutes_i) ==
      $past(avg_minutes_i, 2) && $past(time_alarm_min_i) ==
      $past(time_alarm_min_i, 2) |-> pack_status_word_o[8] ==
      ($past(avg_minutes_i) < $past(time_alarm_min_i)))
      else $error("low time flag wrong");
   a_cycle_step:
   assert property ($past(rst_b_i) && cycle_tally_o != $past(cycle_tally_o)
      |-> cycle_tally_o == $past(cycle_tally_o) + 16'h1)
      else $error("cycle count jumped");
   a_bcast_tie:
   assert property ($stable(pack_mode_word_o) |-> bcast_vc_en_o ==
      (!pack_mode_word_o[14] && !pack_mode_word_o[13]))
      else $error("broadcast enable wrong");
   a_unplug_clear:
   assert property (low_cnt_ff == REMOVE_CYC + 32'h8 |->
      !pack_mode_word_o[14])
      else $error("mode bit kept after removal");
   a_drive_low:
   assert property (scd_out_o == 1'b0)
      else $error("data pin drives high");
   a_hold_high:
   assert property (scc_i [*5] |-> $stable(scd_oe_b_o))
      else $error("data moved, clock high");
   c_dev_drives: cover property (!scd_oe_b_o);
   c_cycle_up: cover property (cycle_tally_o != $past(cycle_tally_o));
   c_unplug: cover property (low_cnt_ff == REMOVE_CYC);
endmodule

bind bgr_readout_regs bgr_readout_monitor #(.REMOVE_CYC(REMOVE_CYC))
   bgr_readout_monitor_i (.clock_i, .rst_b_i, .scc_i, .scd_i, .scd_out_o,
   .scd_oe_b_o, .capacity_left_mah_i, .cap_alarm_mah_i, .avg_minutes_i,
   .time_alarm_min_i, .alarm_flags_i, .state_flags_i, .discharging_i,
   .error_code_i, .pack_status_word_o, .cycle_tally_o, .pack_mode_word_o,
   .bcast_vc_en_o);

/* sim/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] RCYC = 32'h0000_00C8;
   logic         clock_i = 1'b0;
   logic         rst_b_i;
   logic [15:0]  error_margin_pct_i, relative_charge_pct_i;
   logic [15:0]  absolute_charge_pct_i, capacity_left_mah_i;
   logic [15:0]  cfg_full_mah_i, learned_mah_i, run_minutes_i;
   logic [15:0]  avg_minutes_i, charge_current_request_i;
   logic [15:0]  charge_voltage_request_i, cap_alarm_mah_i;
   logic [15:0]  time_alarm_min_i, nominal_capacity_mah_i;
   logic [15:0]  nominal_voltage_mv_i, pack_serial_i;
   logic [127:0] maker_name_string_i, pack_name_string_i, s;
   logic [3:0]   alarm_flags_i, error_code_i, date_month_i;
   logic [2:0]   state_flags_i;
   logic [4:0]   date_day_i;
   logic [6:0]   date_year_i;
   logic         cfg_load_i, learned_valid_i, discharging_i;
   logic         charging_i, charge_done_i;
   wire          scc_i, scd_i, scd_out_o, scd_oe_b_o, bcast_vc_en_o;
   wire  [15:0]  pack_status_word_o, cycle_tally_o, pack_mode_word_o;
   int           mismatches = 0;
   int           total_checks = 0;
   always #4 clock_i = ~clock_i;
   bgr_readout_regs #(.REMOVE_CYC(RCYC)) bgr_readout_regs_i (.clock_i,
      .rst_b_i, .scc_i, .scd_i, .scd_out_o, .scd_oe_b_o, .error_margin_pct_i,
      .relative_charge_pct_i, .absolute_charge_pct_i, .capacity_left_mah_i,
      .cfg_full_mah_i, .cfg_load_i, .learned_mah_i, .learned_valid_i,
      .run_minutes_i, .avg_minutes_i, .charge_current_request_i,
      .charge_voltage_request_i, .cap_alarm_mah_i, .time_alarm_min_i,
      .alarm_flags_i, .state_flags_i, .discharging_i, .charging_i,
      .charge_done_i, .error_code_i, .nominal_capacity_mah_i,
      .nominal_voltage_mv_i, .date_day_i, .date_month_i, .date_year_i,
      .pack_serial_i, .maker_name_string_i, .pack_name_string_i,
      .pack_status_word_o, .cycle_tally_o, .pack_mode_word_o, .bcast_vc_en_o);
   bgr_host_model bgr_host_model_i (.scc_o(scc_i), .scd_o(scd_i),
      .scd_oe_b_i(scd_oe_b_o));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] c, input logic [15:0] e);
      logic [15:0] v;
      bgr_host_model_i.rd_word(c, v);
      chk(v, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // a hung link cannot stall the run past this point
   initial begin
      #600us;
      mismatches++;
      tally_and_finish();
   end
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      rst_b_i = 1'b0;
      error_margin_pct_i = 16'h00C8;
      relative_charge_pct_i = 16'h0065;
      absolute_charge_pct_i = 16'h012C;
      capacity_left_mah_i = 16'h1234;
      cfg_full_mah_i = 16'h0FA0;
      learned_mah_i = 16'h0000;
      run_minutes_i = 16'h00F0;
      avg_minutes_i = 16'h0123;
      charge_current_request_i = 16'hFFFF;
      charge_voltage_request_i = 16'h3A98;
      cap_alarm_mah_i = 16'h2000;
      time_alarm_min_i = 16'h0200;
      nominal_capacity_mah_i = 16'h1F40;
      nominal_voltage_mv_i = 16'h2EE0;
      pack_serial_i = 16'h5A5A;
      maker_name_string_i = {"EDCBA", 8'h05};
      pack_name_string_i = {{15{8'h4E}}, 8'h14};
      alarm_flags_i = 4'hB;
      state_flags_i = 3'h5;
      error_code_i = 4'hA;
      date_day_i = 5'h11;
      date_month_i = 4'h6;
      date_year_i = 7'h13;
      {cfg_load_i, learned_valid_i, charging_i, charge_done_i} = 4'h0;
      discharging_i = 1'b1;
      tick(6);
      rst_b_i <= 1'b1;
      cfg_load_i <= 1'b1;
      tick(1);
      cfg_load_i <= 1'b0;
      tick(4);
      rchk(8'h0C, 16'h0064);
      rchk(8'h0D, 16'h0064);
      rchk(8'h0E, 16'h012C);
      rchk(8'h0F, 16'h1234);
      rchk(8'h10, 16'h0FA0);
      rchk(8'h11, 16'h00F0);
      rchk(8'h12, 16'h0123);
      rchk(8'h14, 16'hFFFF);
      rchk(8'h15, 16'h3A98);
      rchk(8'h16, 16'h9BDA);
      rchk(8'h18, 16'h1F40);
      rchk(8'h19, 16'h2EE0);
      rchk(8'h1A, 16'h0000);
      rchk(8'h1B, 16'h26D1);
      rchk(8'h1C, 16'h5A5A);
      rchk(8'h13, 16'h0000);
      bgr_host_model_i.rd_blk(8'h20, s);
      chk(s, {"EDCBA", 8'h05});
      bgr_host_model_i.rd_blk(8'h21, s);
      chk(s, {{15{8'h4E}}, 8'h0F});
      bgr_host_model_i.wr_word(8'h0F, 16'hBEEF);
      rchk(8'h0F, 16'h1234);
      // learned value beats a same-cycle config load
      tick(1);
      cfg_full_mah_i <= 16'h0111;
      {cfg_load_i, learned_valid_i} <= 2'h3;
      learned_mah_i <= 16'h0BB8;
      alarm_flags_i <= 4'h4;
      state_flags_i <= 3'h2;
      error_code_i <= 4'h5;
      discharging_i <= 1'b0;
      {cap_alarm_mah_i, time_alarm_min_i} <= 32'h0;
      tick(1);
      {cfg_load_i, learned_valid_i} <= 2'h0;
      tick(2);
      @(negedge clock_i) chk(pack_status_word_o, 16'h4025);
      rchk(8'h10, 16'h0BB8);
      rchk(8'h11, 16'hFFFF);
      rchk(8'h16, 16'h4025);
      // 14 point drop: no count; 15 point: one
      tick(1);
      relative_charge_pct_i <= 16'h0050;
      charge_done_i <= 1'b1;
      tick(1);
      charge_done_i <= 1'b0;
      relative_charge_pct_i <= 16'h0042;
      charging_i <= 1'b1;
      tick(8);
      @(negedge clock_i) chk(cycle_tally_o, 16'h0000);
      relative_charge_pct_i <= 16'h0041;
      tick(16);
      @(negedge clock_i) chk(cycle_tally_o, 16'h0001);
      rchk(8'h17, 16'h0001);
      bgr_host_model_i.wr_word(8'h03, 16'h4000);
      rchk(8'h03, 16'h4000);
      chk(bcast_vc_en_o, 1'b0);
      bgr_host_model_i.unplug(2000ns);
      rchk(8'h03, 16'h0000);
      chk(bcast_vc_en_o, 1'b1);
      chk(bgr_host_model_i.nak_cnt, 8'h00);
      tally_and_finish();
   end
endmodule
